// *** mcil_busy_counter.sv ***
// Multiplier busy countdown.
// Assumes load comes from the sequencer on the same clock.
`timescale 1ns/1ps
`default_nettype none
module mcil_busy_counter
(
    // Clock and reset
    input  wire logic                          mclk,
    input  wire logic                          nrst,
    // Load from the multiplier-access stage
    input  wire logic                          load,
    input  wire logic [mcil_pkg::BUSY_W-1:0]   load_value,
    // State
    output logic                               busy,
    output logic [mcil_pkg::BUSY_W-1:0]        count
);

    logic [mcil_pkg::BUSY_W-1:0] next_count;

    // Counts on every clock, so the busy time ignores slot stretching
    always_comb
    begin
        next_count = count;
        if (load)
        begin
            next_count = load_value;
        end
        else if (count != mcil_pkg::MM_NONE)
        begin
            next_count = count - 3'h1;
        end
    end

    always_ff @(posedge mclk or negedge nrst)
    begin
        if (!nrst)
        begin
            count <= mcil_pkg::BUSY_RESET;
        end
        else
        begin
            count <= next_count;
        end
    end

    assign busy = (count != mcil_pkg::MM_NONE);

endmodule // mcil_busy_counter
`default_nettype wire

// *** mcil_interlock.sv ***
// Multiplier contention interlock: sequences the tail stages of each
// instruction after decode and holds multiplier-access stages while busy.
// Assumes decode, fetch and the memory bus run on mclk; bus slot splitting
// between fetch and memory access is arbitrated outside and seen via mem_ready.
//
// Summary of operation
// - MAC loads from memory get no extra memory-access stage; their one stage reaches the multiplier.
// - MAC load multiplier stage stretches while the word multiply is busy; one slot.
// - The MAC load memory-access stage requests the bus, competing with fetch.
// - Double multiplies run EX, two memory stages; the second hands work over.
// - After a double multiply's access stage, multiplier stays busy four cycles.
// - Decode after a double multiply is held for one slot.
// - Both double multiply memory stages share slots with fetch by normal splitting.
// - Without a multiplier user next, double multiply acts as five-stage instruction.
// - Contention handling applies to every multiplier user following a double multiply.
// - Long MAC second memory stage stretches while multiplier busy, for as many cycles as the countdown has left.
// - Two unrelated instructions between double multiply and long MAC avoid stalls.
`timescale 1ns/1ps
`default_nettype none
module mcil_interlock
(
    // Clock and reset
    input  wire logic                   mclk,
    input  wire logic                   nrst,
    // Decode stage
    input  wire mcil_pkg::mcil_decode_t decode,
    output logic                        id_stall,
    // Memory bus
    input  wire logic                   fetch_req,
    input  wire logic                   mem_ready,
    // Multiplier hand-over
    output logic                        mult_start,
    output logic [mcil_pkg::BUSY_W-1:0] mult_cycles,
    // Sequencer state
    output mcil_pkg::mcil_status_t      status,
    output mcil_pkg::mcil_class_t       exec_class,
    output logic                        retire
);

    // ************************************************************
    // Class decoding
    // ************************************************************
    function automatic logic is_double(input mcil_pkg::mcil_class_t c);
        return (c == mcil_pkg::CLS_SIGNED_DOUBLE_MULTIPLY) ||
               (c == mcil_pkg::CLS_UNSIGNED_DOUBLE_MULTIPLY) ||
               (c == mcil_pkg::CLS_LONG_MULTIPLY);
    endfunction

    // Classes with two memory-access stages, the second being the multiplier access
    function automatic logic has_two_ma(input mcil_pkg::mcil_class_t c);
        return is_double(c) ||
               (c == mcil_pkg::CLS_LONG_MAC) ||
               (c == mcil_pkg::CLS_WORD_MAC);
    endfunction

    // Classes whose final stage touches the multiplier
    function automatic logic uses_multiplier(input mcil_pkg::mcil_class_t c);
        return (c != mcil_pkg::CLS_OTHER);
    endfunction

    // Busy time started when the access stage ends; zero for MAC moves
    function automatic logic [mcil_pkg::BUSY_W-1:0] mm_cycles(input mcil_pkg::mcil_class_t c);
        logic [mcil_pkg::BUSY_W-1:0] v;
        v = mcil_pkg::MM_NONE;
        unique case (c)
            mcil_pkg::CLS_SIGNED_DOUBLE_MULTIPLY,
            mcil_pkg::CLS_UNSIGNED_DOUBLE_MULTIPLY,
            mcil_pkg::CLS_LONG_MULTIPLY:        v = mcil_pkg::MM_DOUBLE_CYCLES;
            mcil_pkg::CLS_LONG_MAC:             v = mcil_pkg::MM_LONG_MAC_CYCLES;
            mcil_pkg::CLS_WORD_MAC:             v = mcil_pkg::MM_WORD_MAC_CYCLES;
            mcil_pkg::CLS_SIGNED_WORD_MULTIPLY: v = mcil_pkg::MM_WORD_CYCLES;
            default:                            v = mcil_pkg::MM_NONE;
        endcase
        return v;
    endfunction

    // ************************************************************
    // Sequencer state
    // ************************************************************
    mcil_pkg::mcil_state_t state;
    mcil_pkg::mcil_state_t next_state;
    mcil_pkg::mcil_class_t cur_cls;
    mcil_pkg::mcil_class_t next_cur_cls;
    logic                  dmul_hold;
    logic                  next_dmul_hold;

    logic                  mult_busy;
    logic [mcil_pkg::BUSY_W-1:0] busy_count;
    logic                  mult_go;
    logic                  free;
    logic                  issue;
    logic                  finish;
    logic                  busy_load;
    logic [mcil_pkg::BUSY_W-1:0] busy_value;

    // ************************************************************
    // Busy countdown
    // ************************************************************
    mcil_busy_counter u_busy
    (
        .mclk       (mclk),
        .nrst       (nrst),
        .load       (busy_load),
        .load_value (busy_value),
        .busy       (mult_busy),
        .count      (busy_count)
    );

    // ************************************************************
    // Stage advance
    // ************************************************************
    // The access stage waits for the countdown and, since every access
    // stage is a bus cycle, for the memory bus as well.
    assign mult_go = (state == mcil_pkg::ST_MA_MULT) && !mult_busy && mem_ready;

    always_comb
    begin
        next_state     = state;
        next_cur_cls   = cur_cls;
        next_dmul_hold = 1'b0;
        finish         = 1'b0;
        busy_load      = 1'b0;
        busy_value     = mcil_pkg::MM_NONE;
        unique case (state)
            mcil_pkg::ST_IDLE:
            begin
                next_state = mcil_pkg::ST_IDLE;
            end
            mcil_pkg::ST_EX:
            begin
                if (has_two_ma(cur_cls))
                begin
                    next_state = mcil_pkg::ST_MA_BUS;
                end
                else if (uses_multiplier(cur_cls))
                begin
                    next_state = mcil_pkg::ST_MA_MULT;
                end
                else
                begin
                    next_state = mcil_pkg::ST_IDLE;
                    finish     = 1'b1;
                end
            end
            mcil_pkg::ST_MA_BUS:
            begin
                // First memory stage never waits for the multiplier
                if (mem_ready)
                begin
                    next_state = mcil_pkg::ST_MA_MULT;
                end
            end
            mcil_pkg::ST_MA_MULT:
            begin
                // Held in place while busy: the stretch lasts until the countdown expires, one or more cycles
                if (mult_go)
                begin
                    next_state = mcil_pkg::ST_IDLE;
                    finish     = 1'b1;
                    busy_load  = (mm_cycles(cur_cls) != mcil_pkg::MM_NONE);
                    busy_value = mm_cycles(cur_cls);
                    next_dmul_hold = is_double(cur_cls);
                end
            end
            default:
            begin
                next_state = mcil_pkg::ST_IDLE;
            end
        endcase

        // A finishing double multiply refuses its follower in that cycle too,
        // so the hold lands on the immediate follower and not the one after.
        free  = finish || (state == mcil_pkg::ST_IDLE);
        issue = decode.valid && free && !dmul_hold && !next_dmul_hold;
        if (issue)
        begin
            next_state   = mcil_pkg::ST_EX;
            next_cur_cls = decode.cls;
        end
        else if (finish || (state == mcil_pkg::ST_IDLE))
        begin
            next_cur_cls = mcil_pkg::CLS_OTHER;
        end
    end

    always_ff @(posedge mclk or negedge nrst)
    begin
        if (!nrst)
        begin
            state     <= mcil_pkg::ST_IDLE;
            cur_cls   <= mcil_pkg::CLS_OTHER;
            dmul_hold <= 1'b0;
        end
        else
        begin
            state     <= next_state;
            cur_cls   <= next_cur_cls;
            dmul_hold <= next_dmul_hold;
        end
    end

    // ************************************************************
    // Outputs
    // ************************************************************
    // A follower that never reaches ST_MA_MULT never looks at the
    // countdown, so an unrelated instruction meets only the double multiply decode hold.
    assign id_stall = !free || dmul_hold || next_dmul_hold;

    // Any multiplier user reaches ST_MA_MULT and meets the countdown,
    // so spacing a double multiply's follower by two unrelated instructions lets it expire first.
    assign status.ma_stretch = (state == mcil_pkg::ST_MA_MULT) && mult_busy;

    assign status.ex_active  = (state == mcil_pkg::ST_EX);
    assign status.ma_bus_req = (state == mcil_pkg::ST_MA_BUS) ||
                               (state == mcil_pkg::ST_MA_MULT);
    assign status.ma_fetch_contend = status.ma_bus_req && fetch_req;
    assign status.mult_busy  = mult_busy;

    assign mult_start  = busy_load;
    assign mult_cycles = busy_value;
    assign retire      = finish;
    assign exec_class  = cur_cls;

endmodule // mcil_interlock
`default_nettype wire

// *** mcil_interlock_assertions.sv ***
// Concurrent checks on the multiplier contention interlock ports.
// Assumes one clock domain, mclk, with nrst asynchronous active low.
`timescale 1ns/1ps
`default_nettype none
module mcil_interlock_checker
(
    // Clock and reset
    input wire logic                   mclk,
    input wire logic                   nrst,
    // Observed ports
    input wire mcil_pkg::mcil_decode_t decode,
    input wire logic                   id_stall,
    input wire logic                   fetch_req,
    input wire logic                   mem_ready,
    input wire logic                   mult_start,
    input wire logic [2:0]             mult_cycles,
    input wire mcil_pkg::mcil_status_t status,
    input wire mcil_pkg::mcil_class_t  exec_class,
    input wire logic                   retire
);
    wire is_dbl = exec_class inside {mcil_pkg::CLS_SIGNED_DOUBLE_MULTIPLY,
        mcil_pkg::CLS_UNSIGNED_DOUBLE_MULTIPLY, mcil_pkg::CLS_LONG_MULTIPLY};
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!nrst);
    sequence s_dbl_end;
        retire && is_dbl;
    endsequence
    sequence s_dbl_ex;
        status.ex_active && is_dbl;
    endsequence
    property p_dbl_start; s_dbl_end |-> mult_start && mult_cycles == 3'h4; endproperty
    a_dbl_start: assert property (p_dbl_start) else $error("double multiply start wrong");
    property p_busy4; mult_start && mult_cycles == 3'h4 |=> status.mult_busy [*4]; endproperty
    a_busy4: assert property (p_busy4) else $error("busy not held four cycles");
    property p_hold; s_dbl_end |-> id_stall ##1 id_stall; endproperty
    a_hold: assert property (p_hold) else $error("decode not held after double multiply");
    property p_dbl_ma; s_dbl_ex |=> status.ma_bus_req && !retire; endproperty
    a_dbl_ma: assert property (p_dbl_ma) else $error("double multiply skipped memory stage");
    property p_dbl_two_ma; s_dbl_ex |=> status.ma_bus_req [*2]; endproperty
    a_dbl_two_ma: assert property (p_dbl_two_ma) else $error("double multiply lost a memory stage");
    // The MAC load's access stage is a bus cycle, so fetch contends with it
    property p_contend;
        retire && exec_class == mcil_pkg::CLS_MAC_LOAD_FROM_MEMORY |->
            status.ma_bus_req && (status.ma_fetch_contend == fetch_req);
    endproperty
    a_contend: assert property (p_contend) else $error("fetch contention flag wrong");
    property p_held; status.ma_stretch |-> !mult_start && !retire; endproperty
    a_held: assert property (p_held) else $error("stretched stage ended early");
    property p_no_start_busy; mult_start |-> !status.mult_busy; endproperty
    a_no_start_busy: assert property (p_no_start_busy) else $error("multiplier started while busy");
    property p_word; mult_start && exec_class == mcil_pkg::CLS_SIGNED_WORD_MULTIPLY |-> mult_cycles == 3'h2;
    endproperty
    a_word: assert property (p_word) else $error("word multiply busy count wrong");
    property p_other; status.ex_active && exec_class == mcil_pkg::CLS_OTHER |-> retire && !mult_start;
    endproperty
    a_other: assert property (p_other) else $error("plain instruction not retired in execute");
endmodule // mcil_interlock_checker
bind mcil_interlock mcil_interlock_checker u_chk (.mclk(mclk), .nrst(nrst), .decode(decode),
    .id_stall(id_stall), .fetch_req(fetch_req), .mem_ready(mem_ready), .mult_start(mult_start),
    .mult_cycles(mult_cycles), .status(status), .exec_class(exec_class), .retire(retire));
`default_nettype wire

// *** mcil_pkg.sv ***
// Shared types and constants for the multiplier contention interlock.
// Assumes a single CPU clock domain; decode supplies one instruction class per slot.
package mcil_pkg;

    // ************************************************************
    // Instruction classes seen at decode
    // ************************************************************
    typedef enum logic [3:0] {
        CLS_OTHER                   = 4'h0,
        CLS_SIGNED_WORD_MULTIPLY    = 4'h1,
        CLS_WORD_MAC                = 4'h2,
        CLS_LONG_MAC                = 4'h3,
        CLS_SIGNED_DOUBLE_MULTIPLY  = 4'h4,
        CLS_UNSIGNED_DOUBLE_MULTIPLY= 4'h5,
        CLS_LONG_MULTIPLY           = 4'h6,
        CLS_MAC_LOAD_FROM_MEMORY    = 4'h7,
        CLS_MAC_LOAD_FROM_REGISTER  = 4'h8,
        CLS_MAC_STORE_TO_MEMORY     = 4'h9,
        CLS_MAC_STORE_TO_REGISTER   = 4'ha
    } mcil_class_t;

    // ************************************************************
    // Sequencer states, one-hot
    // ************************************************************
    typedef enum logic [3:0] {
        ST_IDLE    = 4'b0001,
        ST_EX      = 4'b0010,
        ST_MA_BUS  = 4'b0100,
        ST_MA_MULT = 4'b1000
    } mcil_state_t;

    // ************************************************************
    // Carriers
    // ************************************************************
    typedef struct packed {
        logic        valid;
        mcil_class_t cls;
    } mcil_decode_t;

    typedef struct packed {
        logic ex_active;
        logic ma_bus_req;
        logic ma_fetch_contend;
        logic ma_stretch;
        logic mult_busy;
    } mcil_status_t;

    // ************************************************************
    // Timing counts, in clock cycles
    // ************************************************************
    localparam int          BUSY_W            = 3;
    localparam logic [2:0]  MM_DOUBLE_CYCLES  = 3'h4;
    localparam logic [2:0]  MM_LONG_MAC_CYCLES= 3'h4;
    localparam logic [2:0]  MM_WORD_CYCLES    = 3'h2;
    localparam logic [2:0]  MM_WORD_MAC_CYCLES= 3'h2;
    localparam logic [2:0]  MM_NONE           = 3'h0;
    localparam logic [2:0]  BUSY_RESET        = 3'h0;

endpackage

// *** tb_multiplier_contention_interlock.sv ***
// Self-checking bench for the multiplier contention interlock.
// Assumes the bench plays decode and the memory bus; checker is bound in.
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin n_errors++; \
    $display("BAD %s exp %0h got %0h", nm, e, g); end end
module tb_multiplier_contention_interlock;
    logic mclk, nrst, fetch_req, mem_ready, id_stall, mult_start, retire;
    logic [2:0] mult_cycles;
    mcil_pkg::mcil_decode_t decode;
    mcil_pkg::mcil_status_t status;
    mcil_pkg::mcil_class_t  exec_class;
    int n_errors = 0, n_checks = 0, n_stretch = 0, n_stall, n_wait;
    logic [2:0] seen_cycles;
    logic seen_start, seen_stall;
    mcil_interlock dut (.mclk(mclk), .nrst(nrst), .decode(decode), .id_stall(id_stall),
        .fetch_req(fetch_req), .mem_ready(mem_ready), .mult_start(mult_start),
        .mult_cycles(mult_cycles), .status(status), .exec_class(exec_class), .retire(retire));
    initial
    begin
        mclk = 0;
        forever #5 mclk = ~mclk;
    end
    always @(negedge mclk) if (status.ma_stretch === 1'b1) n_stretch++;
    task automatic results();
        $display("checks %0d errors %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    // Holds valid up so back to back issues never drop it in between
    task automatic issue(input mcil_pkg::mcil_class_t c);
        decode.valid = 1'b1;
        decode.cls = c;
        n_stall = 0;
        @(negedge mclk);
        while (id_stall !== 1'b0 && n_stall < 40)
        begin
            n_stall++;
            @(negedge mclk);
        end
        @(posedge mclk);
        #1;
    endtask
    task automatic wait_retire();
        n_wait = 0;
        @(negedge mclk);
        while (retire !== 1'b1 && n_wait < 40)
        begin
            n_wait++;
            @(negedge mclk);
        end
        // Pulses stand only in the retiring cycle
        seen_start  = mult_start;
        seen_cycles = mult_cycles;
        seen_stall  = id_stall;
        @(posedge mclk);
        #1;
    endtask
    task automatic drain();
        decode.valid = 1'b0;
        repeat (12) @(posedge mclk);
        #1;
    endtask
    task automatic t_double_walk();
        issue(mcil_pkg::CLS_SIGNED_DOUBLE_MULTIPLY);
        `CHK("exec class", mcil_pkg::CLS_SIGNED_DOUBLE_MULTIPLY, exec_class)
        `CHK("ex active", 1'b1, status.ex_active)
        decode.valid = 1'b0;
        wait_retire();
        `CHK("retire delay", 2, n_wait)
        `CHK("mult start", 1'b1, seen_start)
        `CHK("busy count", mcil_pkg::MM_DOUBLE_CYCLES, seen_cycles)
        `CHK("hold at retire", 1'b1, seen_stall)
        `CHK("mult busy", 1'b1, status.mult_busy)
        issue(mcil_pkg::CLS_OTHER);
        `CHK("decode hold", 1, n_stall)
        decode.valid = 1'b0;
        wait_retire();
        `CHK("plain retire", 0, n_wait)
        drain();
    endtask
    task automatic t_slow_bus();
        mem_ready = 1'b0;
        fetch_req = 1'b1;
        issue(mcil_pkg::CLS_LONG_MULTIPLY);
        decode.valid = 1'b0;
        repeat (3) @(negedge mclk);
        `CHK("bus wait", 1'b1, status.ma_fetch_contend)
        `CHK("no early retire", 1'b0, retire)
        @(posedge mclk);
        #1;
        mem_ready = 1'b1;
        fetch_req = 1'b0;
        wait_retire();
        `CHK("retired", 1, n_wait < 40)
        drain();
    endtask
    // Last row: a long MAC's four busy cycles outlast its follower's EX and first MA by two
    mcil_pkg::mcil_class_t ta[9] = '{mcil_pkg::CLS_SIGNED_WORD_MULTIPLY, mcil_pkg::CLS_SIGNED_DOUBLE_MULTIPLY,
        mcil_pkg::CLS_UNSIGNED_DOUBLE_MULTIPLY, mcil_pkg::CLS_LONG_MULTIPLY, mcil_pkg::CLS_SIGNED_DOUBLE_MULTIPLY,
        mcil_pkg::CLS_SIGNED_DOUBLE_MULTIPLY, mcil_pkg::CLS_SIGNED_DOUBLE_MULTIPLY,
        mcil_pkg::CLS_SIGNED_DOUBLE_MULTIPLY, mcil_pkg::CLS_LONG_MAC};
    mcil_pkg::mcil_class_t tb[9] = '{mcil_pkg::CLS_MAC_LOAD_FROM_MEMORY, mcil_pkg::CLS_MAC_LOAD_FROM_REGISTER,
        mcil_pkg::CLS_SIGNED_WORD_MULTIPLY, mcil_pkg::CLS_MAC_STORE_TO_MEMORY, mcil_pkg::CLS_MAC_STORE_TO_REGISTER,
        mcil_pkg::CLS_MAC_LOAD_FROM_MEMORY, mcil_pkg::CLS_LONG_MAC, mcil_pkg::CLS_MAC_LOAD_FROM_REGISTER,
        mcil_pkg::CLS_WORD_MAC};
    int tn[9] = '{0, 0, 0, 0, 0, 0, 2, 2, 0};
    int te[9] = '{1, 1, 1, 1, 1, 1, 0, 0, 2};
    // A busy multiplier stretches the follower's access stage by the cycles left
    task automatic t_followers();
        for (int r = 0; r < 9; r++)
        begin
            fetch_req = r[0];
            issue(ta[r]);
            repeat (tn[r]) issue(mcil_pkg::CLS_OTHER);
            n_stretch = 0;
            issue(tb[r]);
            decode.valid = 1'b0;
            wait_retire();
            `CHK("stretch", te[r], n_stretch)
            drain();
        end
    endtask
    initial
    begin
        nrst = 1'b0;
        decode = '0;
        fetch_req = 1'b0;
        mem_ready = 1'b1;
        repeat (6) @(posedge mclk);
        #1;
        nrst = 1'b1;
        t_double_walk();
        t_slow_bus();
        t_followers();
        results();
    end
    initial
    begin
        #20000;
        n_errors++;
        results();
    end
endmodule // tb_multiplier_contention_interlock
`default_nettype wire
